// file: logic/evr_consts.vh
// Constants for the exception vector resolution block
`ifndef EVR_CONSTS_VH
`define EVR_CONSTS_VH
`define EVR_NUM_W        8
`define EVR_PRI_W        3
`define EVR_CFG_W        4
`define EVR_IRQ_N        82
`define EVR_IRQ_W        7
`define EVR_EXC_RESET    8'h01
`define EVR_EXC_NMI      8'h02
`define EVR_EXC_HARD     8'h03
`define EVR_EXC_MEM      8'h04
`define EVR_EXC_BUS      8'h05
`define EVR_EXC_USAGE    8'h06
`define EVR_EXC_SVC      8'h0B
`define EVR_EXC_PENDSRV  8'h0E
`define EVR_EXC_TICK     8'h0F
`define EVR_EXC_IRQ0     8'h10
`define EVR_EXC_MAX      8'hFF
`define EVR_EXC_NONE     8'h00
`define EVR_PRI_RESET    5'h1D
`define EVR_PRI_NMI      5'h1E
`define EVR_PRI_HARD     5'h1F
`define EVR_PRI_NONE     5'h0F
`define EVR_SP_OFFSET    32'h0000_0000
`define EVR_BASE_RESET   32'h0000_0000
`define EVR_BASE_MIN     32'h0000_0080
`define EVR_BASE_MAX     32'h3FFF_FF80
`define EVR_BASE_MASK    32'hFFFF_FF80
`define EVR_IRQ_OFFSET   32'h0000_0040
`define EVR_VEC_STEP_SH  2
`define EVR_SYS_N        7
`endif

// file: logic/evr_exception_vector_resolution.v
// Exception source resolution into number, priority, kind and vector address
`timescale 1ns/10ps
`include "evr_consts.vh"
module evr_exception_vector_resolution (
  input  wire                           clk,
  input  wire                           reset,
  input  wire                           nmiRequest,
  input  wire                           hardFaultRequest,
  input  wire                           memFaultRequest,
  input  wire                           busFaultRequest,
  input  wire                           busFaultPrecise,
  input  wire                           usageFaultRequest,
  input  wire                           svcRequest,
  input  wire                           pendSrvRequest,
  input  wire                           timerZero,
  input  wire                           tickSoftRequest,
  input  wire [`EVR_IRQ_N-1:0]          irqLines,
  input  wire [`EVR_IRQ_N-1:0]          irqSoftRequest,
  input  wire [`EVR_IRQ_N-1:0]          irqEnable,
  input  wire [`EVR_SYS_N-1:0]          sysEnable,
  input  wire [`EVR_IRQ_N*4-1:0]        irqPriority,
  input  wire [`EVR_SYS_N*4-1:0]        sysPriority,
  input  wire                           privileged,
  input  wire                           relocWrite,
  input  wire [31:0]                    relocData,
  input  wire                           entryAck,
  input  wire                           entryDone,
  input  wire                           spFetchReq,
  output reg                            takeValid,
  output reg  [`EVR_NUM_W-1:0]          takeNumber,
  output reg  [`EVR_NUM_W:0]            takeLineIndex,
  output reg  [4:0]                     takePriority,
  output reg                            takeAsync,
  output reg                            takeOneMoreInsn,
  output reg                            takeIsIsr,
  output reg  [31:0]                    vectorAddr,
  output reg  [31:0]                    spAddr,
  output reg  [31:0]                    tableBase,
  output reg                            relocRejected,
  output reg  [`EVR_NUM_W-1:0]          statusField
);

  // Pending flags: index 0..6 system sources, then external lines
  reg [`EVR_SYS_N-1:0]   sysPend_q;
  reg [`EVR_IRQ_N-1:0]   irqPend_q;
  reg [`EVR_SYS_N-1:0]   sysPend_d;
  reg [`EVR_IRQ_N-1:0]   irqPend_d;
  reg                    nmiS1_q, nmiS2_q;
  reg [`EVR_IRQ_N-1:0]   irqS1_q, irqS2_q;
  reg                    busPrecLatch_q;
  reg [31:0]             tableBase_q;
  reg [`EVR_NUM_W-1:0]   ackNum_q;

  // System slot to exception number
  function [`EVR_NUM_W-1:0] sysNumber;
    input [2:0] slot;
    begin
      case (slot)
        3'd0: sysNumber = `EVR_EXC_NMI;
        3'd1: sysNumber = `EVR_EXC_HARD;
        3'd2: sysNumber = `EVR_EXC_MEM;
        3'd3: sysNumber = `EVR_EXC_BUS;
        3'd4: sysNumber = `EVR_EXC_USAGE;
        3'd5: sysNumber = `EVR_EXC_SVC;
        3'd6: sysNumber = `EVR_EXC_PENDSRV;
        default: sysNumber = `EVR_EXC_TICK;
      endcase
    end
  endfunction

  // Vector entry address for an exception number
  function [31:0] vecAddr;
    input [31:0]            base;
    input [`EVR_NUM_W-1:0]  num;
    begin
      vecAddr = base + ({24'h00_0000, num} << `EVR_VEC_STEP_SH);
    end
  endfunction

  // Signed compare: fixed codes 0x1D..0x1F stand for -3..-1
  function prio_lt;
    input [4:0] a;
    input [4:0] b;
    begin
      prio_lt = ($signed(a) < $signed(b));
    end
  endfunction

  // Asynchronous activation: NMI, imprecise bus fault, pendable service, tick, lines
  function isAsync;
    input [`EVR_NUM_W-1:0]  num;
    input                   busPrecise;
    begin
      isAsync = (num >= `EVR_EXC_PENDSRV) ||
                (num == `EVR_EXC_NMI) ||
                (num == `EVR_EXC_BUS && !busPrecise);
    end
  endfunction

  // Signed line index: exception number less the first external number
  function [`EVR_NUM_W:0] lineIndex;
    input [`EVR_NUM_W-1:0]  num;
    begin
      lineIndex = {1'b0, num} - {1'b0, `EVR_EXC_IRQ0};
    end
  endfunction

  // Relocation accepted only when privileged and inside the allowed window
  function baseOk;
    input                   priv;
    input [31:0]            data;
    reg   [31:0]            masked;
    begin
      masked = data & `EVR_BASE_MASK;
      baseOk = priv && (masked >= `EVR_BASE_MIN) && (masked <= `EVR_BASE_MAX);
    end
  endfunction

  // Configurable field widened to the signed priority scale
  function [4:0] cfgPri;
    input [`EVR_CFG_W-1:0]  field;
    begin
      cfgPri = {1'b0, field};
    end
  endfunction

  // External line index to exception number
  function [`EVR_NUM_W-1:0] irqNumber;
    input [`EVR_IRQ_W-1:0]  line;
    begin
      irqNumber = `EVR_EXC_IRQ0 + {1'b0, line};
    end
  endfunction

  // Pending update: set wins over clear on entry
  reg                    tickPend_q;
  reg                    tickPend_d;
  integer                i;
  always @* begin
    sysPend_d = sysPend_q;
    irqPend_d = irqPend_q;
    tickPend_d = tickPend_q;
    if (entryAck && takeValid) begin
      for (i = 0; i < `EVR_SYS_N; i = i + 1)
        if (sysNumber(i[2:0]) == takeNumber)
          sysPend_d[i] = 1'b0;
      if (takeNumber == `EVR_EXC_TICK)
        tickPend_d = 1'b0;
      for (i = 0; i < `EVR_IRQ_N; i = i + 1)
        if (takeNumber == irqNumber(i[6:0]))
          irqPend_d[i] = 1'b0;
    end
    sysPend_d[0] = sysPend_d[0] | nmiS2_q;
    sysPend_d[1] = sysPend_d[1] | hardFaultRequest;
    sysPend_d[2] = sysPend_d[2] | memFaultRequest;
    sysPend_d[3] = sysPend_d[3] | busFaultRequest;
    sysPend_d[4] = sysPend_d[4] | usageFaultRequest;
    sysPend_d[5] = sysPend_d[5] | svcRequest;
    sysPend_d[6] = sysPend_d[6] | pendSrvRequest;
    tickPend_d = tickPend_d | timerZero | tickSoftRequest;
    irqPend_d = irqPend_d | irqS2_q | irqSoftRequest;
  end

  // Arbitration: lowest priority value, then lowest number
  reg [4:0]              bestPri;
  reg [`EVR_NUM_W-1:0]   bestNum;
  reg [4:0]              candPri;
  reg                    candOn;
  integer                j;
  always @* begin
    bestPri = `EVR_PRI_NONE;
    bestNum = `EVR_EXC_NONE;
    candPri = `EVR_PRI_NONE;
    candOn = 1'b0;
    for (j = `EVR_SYS_N; j >= 0; j = j - 1) begin
      if (j == `EVR_SYS_N) begin
        candOn = tickPend_q && sysEnable[`EVR_SYS_N-1];
        candPri = cfgPri(sysPriority[`EVR_SYS_N*4-1 -: 4]);
      end else if (j < 2) begin
        candOn = sysPend_q[j];
        candPri = (j == 0) ? `EVR_PRI_NMI : `EVR_PRI_HARD;
      end else begin
        candOn = sysPend_q[j] && sysEnable[j-2];
        candPri = cfgPri(sysPriority[(j-2)*4 +: 4]);
      end
      if (candOn && (prio_lt(candPri, bestPri) || candPri == bestPri)) begin
        bestPri = candPri;
        bestNum = (j == `EVR_SYS_N) ? `EVR_EXC_TICK : sysNumber(j[2:0]);
      end
    end
    for (j = `EVR_IRQ_N-1; j >= 0; j = j - 1) begin
      candPri = cfgPri(irqPriority[j*4 +: 4]);
      if (irqPend_q[j] && irqEnable[j] && !prio_lt(bestPri, candPri) &&
          !(bestNum != `EVR_EXC_NONE && bestNum < `EVR_EXC_IRQ0 && bestPri == candPri)) begin
        bestPri = candPri;
        bestNum = irqNumber(j[6:0]);
      end
    end
  end

  // Two-stage synchronisers for pins from outside the clock domain
  always @(posedge clk) begin
    if (reset) begin
      nmiS1_q <= 1'b0;
      nmiS2_q <= 1'b0;
      irqS1_q <= {`EVR_IRQ_N{1'b0}};
      irqS2_q <= {`EVR_IRQ_N{1'b0}};
    end else begin
      nmiS1_q <= nmiRequest;
      nmiS2_q <= nmiS1_q;
      irqS1_q <= irqLines;
      irqS2_q <= irqS1_q;
    end
  end

  // Pending state and bus fault kind
  always @(posedge clk) begin
    if (reset) begin
      sysPend_q <= {`EVR_SYS_N{1'b0}};
      irqPend_q <= {`EVR_IRQ_N{1'b0}};
      tickPend_q <= 1'b0;
      busPrecLatch_q <= 1'b0;
    end else begin
      sysPend_q <= sysPend_d;
      irqPend_q <= irqPend_d;
      tickPend_q <= tickPend_d;
      if (busFaultRequest)
        busPrecLatch_q <= busFaultPrecise;
    end
  end

  // Relocation register, refusal pulse and visible base
  always @(posedge clk) begin
    if (reset) begin
      tableBase_q <= `EVR_BASE_RESET;
      tableBase <= `EVR_BASE_RESET;
      spAddr <= `EVR_BASE_RESET + `EVR_SP_OFFSET;
      relocRejected <= 1'b0;
    end else begin
      relocRejected <= 1'b0;
      if (relocWrite) begin
        if (baseOk(privileged, relocData))
          tableBase_q <= relocData & `EVR_BASE_MASK;
        else
          relocRejected <= 1'b1;
      end
      tableBase <= tableBase_q;
      spAddr <= tableBase_q + `EVR_SP_OFFSET;
    end
  end

  // Number taken by the core, reported once entry completes
  always @(posedge clk) begin
    if (reset) begin
      ackNum_q <= `EVR_EXC_NONE;
      statusField <= `EVR_EXC_NONE;
    end else begin
      if (entryAck && takeValid)
        ackNum_q <= takeNumber;
      if (entryDone)
        statusField <= ackNum_q;
    end
  end

  // Offer of the most urgent enabled exception; reset offer held until taken
  always @(posedge clk) begin
    if (reset) begin
      takeValid <= 1'b1;
      takeNumber <= `EVR_EXC_RESET;
      takeLineIndex <= lineIndex(`EVR_EXC_RESET);
      takePriority <= `EVR_PRI_RESET;
      takeAsync <= 1'b1;
      takeOneMoreInsn <= 1'b0;
      takeIsIsr <= 1'b0;
      vectorAddr <= vecAddr(`EVR_BASE_RESET, `EVR_EXC_RESET);
    end else if (!(takeValid && takeNumber == `EVR_EXC_RESET && !entryAck)) begin
      takeValid <= (bestNum != `EVR_EXC_NONE) && !(entryAck && takeValid);
      takeNumber <= bestNum;
      takeLineIndex <= lineIndex(bestNum);
      takePriority <= bestPri;
      takeAsync <= isAsync(bestNum, busPrecLatch_q);
      takeOneMoreInsn <= isAsync(bestNum, busPrecLatch_q);
      takeIsIsr <= (bestNum >= `EVR_EXC_IRQ0);
      vectorAddr <= vecAddr(tableBase_q, bestNum);
    end
  end

endmodule

// file: bench/evr_monitor.sv
// Assertion checker for the exception vector resolution block
`timescale 1ns/10ps
`include "evr_consts.vh"
module evr_monitor (
  input wire        clk,
  input wire        reset,
  input wire        privileged,
  input wire        relocWrite,
  input wire [31:0] relocData,
  input wire        entryAck,
  input wire        entryDone,
  input wire        takeValid,
  input wire [7:0]  takeNumber,
  input wire [8:0]  takeLineIndex,
  input wire [4:0]  takePriority,
  input wire        takeIsIsr,
  input wire [31:0] vectorAddr,
  input wire [31:0] tableBase,
  input wire        relocRejected,
  input wire [7:0]  statusField
);
  wire [31:0] relocMasked = relocData & `EVR_BASE_MASK;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Write that must be turned away
  sequence relocBad;
    relocWrite && (!privileged || relocMasked < `EVR_BASE_MIN || relocMasked > `EVR_BASE_MAX);
  endsequence
  // Core reports handler entry
  sequence doneSeen;
    entryDone;
  endsequence
  // Core accepts the standing offer
  sequence ackSeen;
    entryAck && takeValid;
  endsequence
  chk_reloc_refuse: assert property (relocBad |-> ##[1:2] relocRejected)
    else $error("refused write not flagged");
  chk_status_load: assert property (ackSeen ##1 doneSeen |=> statusField == $past(takeNumber, 2))
    else $error("status field not loaded");
  chk_vector_addr: assert property (takeValid && $stable(tableBase) |-> vectorAddr == tableBase + {takeNumber, 2'b00})
    else $error("vector address wrong");
  chk_line_index: assert property (takeValid |-> takeLineIndex == {1'b0, takeNumber} - 9'h010)
    else $error("line index wrong");
  chk_fixed_prio: assert property (takeValid && takeNumber != 8'h00 && takeNumber <= 8'h03 |-> takePriority == 5'h1C + takeNumber[4:0])
    else $error("fixed priority wrong");
  chk_cfg_range: assert property (takeValid && takeNumber > 8'h03 |-> !takePriority[4])
    else $error("configurable priority out of range");
  chk_isr_flag: assert property (takeValid |-> takeIsIsr == (takeNumber >= 8'h10 && takeNumber < 8'h62))
    else $error("service routine flag wrong");
  chk_base_align: assert property (tableBase[6:0] == 7'h00 && tableBase <= `EVR_BASE_MAX)
    else $error("table base misaligned");
endmodule
bind evr_exception_vector_resolution evr_monitor u_mon (.clk, .reset, .privileged, .relocWrite, .relocData, .entryAck,
  .entryDone,
  .takeValid, .takeNumber, .takeLineIndex, .takePriority, .takeIsIsr, .vectorAddr, .tableBase, .relocRejected,
  .statusField);

// file: bench/evr_core_model.sv
// Core model that accepts offered exceptions on command
`timescale 1ns/10ps
module evr_core_model (
  input  wire        clk,
  input  wire        takeValid,
  input  wire [31:0] vectorAddr,
  input  wire        go,
  output reg         entryAck,
  output reg         entryDone
);
  reg [31:0] handlerWord;
  initial begin
    entryAck = 1'b0;
    entryDone = 1'b0;
    handlerWord = 32'h0000_0001;
  end
  // Accept only a standing offer, then report entry one cycle later
  always @(negedge clk) begin
    entryDone <= entryAck;
    entryAck <= go && takeValid && !entryAck;
    if (go && takeValid && !entryAck)
      handlerWord <= {vectorAddr[31:1], 1'b1};
  end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the exception vector resolution block
`timescale 1ns/10ps
`include "evr_consts.vh"
`define CHK(nm, e, s) begin numChecks = numChecks + 1; if ((s) !== (e)) begin badCount = badCount + 1; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_top;
  reg          clk = 1'b0, reset = 1'b1, privileged = 1'b1, relocWrite = 1'b0, go = 1'b0;
  reg  [9:0]   src = 10'h000;
  reg  [81:0]  irqLines = {82{1'b0}}, irqSoft = {82{1'b0}}, irqEnable = {82{1'b1}};
  reg  [6:0]   sysEnable = 7'h7F;
  reg  [327:0] irqPriority = {328{1'b0}};
  reg  [27:0]  sysPriority = 28'h000_0000;
  reg  [31:0]  relocData = 32'h0000_0000, base = 32'h0000_0000;
  integer      badCount = 0, numChecks = 0, seed = 32'h0000_643F, i, r;
  integer      expN [0:9], slot [0:9], asy [0:9];
  wire         entryAck, entryDone, takeValid, takeAsync, takeOneMoreInsn, takeIsIsr, relocRejected;
  wire [7:0]   takeNumber, statusField;
  wire [8:0]   takeLineIndex;
  wire [4:0]   takePriority;
  wire [31:0]  vectorAddr, spAddr, tableBase;
  always #4 clk = ~clk;
  evr_exception_vector_resolution dut (.clk, .reset, .nmiRequest(src[0]), .hardFaultRequest(src[1]),
    .memFaultRequest(src[2]), .busFaultRequest(src[3] | src[4]), .busFaultPrecise(src[3]), .usageFaultRequest(src[5]),
    .svcRequest(src[6]), .pendSrvRequest(src[7]), .timerZero(src[8]), .tickSoftRequest(src[9]), .irqLines,
    .irqSoftRequest(irqSoft), .irqEnable, .sysEnable, .irqPriority, .sysPriority, .privileged, .relocWrite, .relocData,
    .entryAck, .entryDone, .spFetchReq(1'b0), .takeValid, .takeNumber, .takeLineIndex, .takePriority, .takeAsync,
    .takeOneMoreInsn, .takeIsIsr, .vectorAddr, .spAddr, .tableBase, .relocRejected, .statusField);
  evr_core_model core (.clk, .takeValid, .vectorAddr, .go, .entryAck, .entryDone);
  task conclude;
    begin
      if (badCount == 0 && numChecks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  // Wait for an offer, compare it with the model, let the core enter it
  task enter(input [7:0] n, input [4:0] p, input a);
    integer k;
    begin
      for (k = 0; k < 12 && takeValid !== 1'b1; k = k + 1) @(negedge clk);
      if (k == 12) begin
        badCount = badCount + 1;
        conclude;
      end else begin
        `CHK("number", n, takeNumber)
        `CHK("vector", base + {n, 2'b00}, vectorAddr)
        `CHK("line", {1'b0, n} - 9'h010, takeLineIndex)
        `CHK("prio", p, takePriority)
        `CHK("isr", n >= 8'h10, takeIsIsr)
        if (n > 8'h03) `CHK("async", {a, a}, {takeAsync, takeOneMoreInsn})
        go <= 1'b1;
        @(negedge clk) go <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("status", n, statusField)
      end
    end
  endtask
  task fire(input integer j);
    begin
      @(negedge clk) src[j] <= 1'b1;
      @(negedge clk) src <= 10'h000;
    end
  endtask
  // Write the relocation register and follow the expected base
  task reloc(input [31:0] d, input pv);
    reg [31:0] m;
    reg        seen;
    begin
      m = d & 32'hFFFF_FF80;
      @(negedge clk) {relocData, privileged, relocWrite} <= {d, pv, 1'b1};
      @(negedge clk) relocWrite <= 1'b0;
      seen = relocRejected;
      @(negedge clk) seen = seen | relocRejected;
      if (pv && m >= 32'h0000_0080 && m <= 32'h3FFF_FF80) base = m;
      else seen = !seen;
      `CHK("reject", 1'b0, seen)
      `CHK("base", base, tableBase)
      `CHK("sp", base, spAddr)
    end
  endtask
  initial begin
    expN = '{2, 3, 4, 5, 5, 6, 11, 14, 15, 15};
    slot = '{0, 0, 0, 1, 1, 2, 3, 4, 6, 6};
    asy = '{1, 1, 0, 0, 1, 0, 0, 1, 1, 1};
    for (i = 0; i < 82; i = i + 1) irqPriority[i*4 +: 4] = $random(seed);
    sysPriority = $random(seed);
    repeat (6) @(negedge clk);
    `CHK("rstValid", 1'b1, takeValid)
    `CHK("rstBase", 32'h0000_0000, tableBase)
    reset <= 1'b0;
    enter(8'h01, 5'h1D, 1'b1);
    reloc(32'h0000_007F, 1'b1);
    reloc(32'h4000_0000, 1'b1);
    reloc(32'h0000_1000, 1'b0);
    reloc(32'h3FFF_FFFF, 1'b1);
    reloc(({$random(seed)} & 32'h3FFF_FF80) | 32'h0000_0080, 1'b1);
    for (i = 0; i < 10; i = i + 1) begin
      fire(i);
      enter(expN[i], i < 2 ? 5'h1E + i : {1'b0, sysPriority[slot[i]*4 +: 4]}, asy[i]);
    end
    sysEnable <= 7'h77;
    fire(6);
    repeat (6) @(negedge clk);
    `CHK("masked", 1'b0, takeValid)
    sysEnable <= 7'h7F;
    enter(8'h0B, {1'b0, sysPriority[15:12]}, 1'b0);
    irqPriority[3:0] <= 4'h5;
    irqPriority[327:324] <= 4'h5;
    irqSoft <= {1'b1, {80{1'b0}}, 1'b1};
    @(negedge clk) irqSoft <= {82{1'b0}};
    enter(8'h10, 5'h05, 1'b1);
    enter(8'h61, 5'h05, 1'b1);
    irqPriority[43:40] <= 4'h7;
    irqPriority[83:80] <= 4'h2;
    irqSoft <= 82'h10_0400;
    @(negedge clk) irqSoft <= {82{1'b0}};
    enter(8'h24, 5'h02, 1'b1);
    enter(8'h1A, 5'h07, 1'b1);
    r = {$random(seed)} % 82;
    irqLines[r] <= 1'b1;
    @(negedge clk) irqLines <= {82{1'b0}};
    enter(8'h10 + r, {1'b0, irqPriority[r*4 +: 4]}, 1'b1);
    conclude;
  end
endmodule
